// [core/status_defines.vh]
// command selects, bit positions, masks and sizes of the status block
// assumes the command decoder uses these select codes
`ifndef STATUS_DEFINES_VH
`define STATUS_DEFINES_VH

// =====================================================
// command selects
`define SEL_W 4
`define SEL_CLS 4'h0
`define SEL_ESE_WR 4'h1
`define SEL_ESE_RD 4'h2
`define SEL_ESR_RD 4'h3
`define SEL_OPC 4'h4
`define SEL_OPC_RD 4'h5
`define SEL_PSC_WR 4'h6
`define SEL_PSC_RD 4'h7
`define SEL_SRE_WR 4'h8
`define SEL_SRE_RD 4'h9
`define SEL_STB_RD 4'hA
`define SEL_QEN_WR 4'hB
`define SEL_QEN_RD 4'hC
`define SEL_QEV_RD 4'hD
`define SEL_PRESET 4'hE
`define SEL_ERR_RD 4'hF

// =====================================================
// standard event bits
`define ESR_OPC 0
`define ESR_QUERY 2
`define ESR_DEVICE 3
`define ESR_EXEC 4
`define ESR_CMD 5
`define ESR_PON 7
`define ESR_VALID 8'hBD

// =====================================================
// questionable data bits
`define QUES_VOLT 0
`define QUES_CURR 1
`define QUES_OHM 9
`define QUES_LO 11
`define QUES_HI 12
`define QUES_VALID 16'h1A03

// =====================================================
// status byte bits
`define STB_QUES 3
`define STB_MAV 4
`define STB_ESB 5
`define STB_RQS 6
`define SRE_SUM_MASK 8'h38

// =====================================================
// reset values and error queue
`define MASK8_RST 8'h00
`define MASK16_RST 16'h0000
`define OPC_REPLY 16'h0001
`define ERR_DEPTH 20
`define ERR_PTR_W 5
`define ERR_LAST 5'h13
`define ERR_W 16
`define ERR_NONE 16'h0000

`endif

// [core/event_latch.v]
// sticky event register with a set-wins clear and fixed unused bits
// assumes set inputs are synchronous condition levels
`default_nettype none

module event_latch #(
    parameter W = 8,
    parameter [W-1:0] VALID = {W{1'b1}}
) (
    // clock and reset
    input wire clk_in,
    input wire rst_in,
    // events and clear
    input wire [W-1:0] set_in,
    input wire clr_in,
    output wire [W-1:0] q_out
);

    // =====================================================
    // one sticky bit per position set in VALID, other positions read zero
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1)
        begin : g_bit
            if (VALID[i])
            begin : g_used
                reg bit_reg;
                always @(posedge clk_in or posedge rst_in)
                begin
                    if (rst_in)
                        bit_reg <= 1'b0;
                    else
                        bit_reg <= (bit_reg & ~clr_in) | set_in[i];
                end
                assign q_out[i] = bit_reg;
            end
            else
            begin : g_unused
                assign q_out[i] = 1'b0;
            end
        end
    endgenerate

endmodule

`default_nettype wire

// [core/error_queue.v]
// first-in first-out store of error entries
// assumes each entry is a code that names a message of up to 80 characters
`include "status_defines.vh"
`default_nettype none

module error_queue (
    // clock and reset
    input wire clk_in,
    input wire rst_in,
    // producer
    input wire push_in,
    input wire [15:0] data_in,
    output wire full_out,
    // consumer
    input wire pop_in,
    output wire [15:0] head_out,
    output wire empty_out
);

    // =====================================================
    // storage and pointers
    reg [15:0] mem [0:`ERR_DEPTH-1];
    reg [4:0] wr_reg;
    reg [4:0] rd_reg;
    reg [4:0] cnt_reg;

    wire do_push = push_in & ~full_out;
    wire do_pop = pop_in & ~empty_out;

    assign full_out = (cnt_reg == 5'h14);
    assign empty_out = (cnt_reg == 5'h00);
    assign head_out = empty_out ? `ERR_NONE : mem[rd_reg];

    // entries arriving while full are dropped, older errors are kept
    always @(posedge clk_in)
    begin
        if (do_push)
            mem[wr_reg] <= data_in;
    end

    always @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            wr_reg <= 5'h00;
            rd_reg <= 5'h00;
            cnt_reg <= 5'h00;
        end
        else
        begin
            if (do_push)
                wr_reg <= (wr_reg == `ERR_LAST) ? 5'h00 : wr_reg + 5'h01;
            if (do_pop)
                rd_reg <= (rd_reg == `ERR_LAST) ? 5'h00 : rd_reg + 5'h01;
            if (do_push & ~do_pop)
                cnt_reg <= cnt_reg + 5'h01;
            else if (do_pop & ~do_push)
                cnt_reg <= cnt_reg - 5'h01;
        end
    end

endmodule

`default_nettype wire

// [core/status_reporting_registers.v]
// status byte, standard event, questionable data and error queue block
// assumes a command decoder issuing one-cycle strobes and an nv store
`include "status_defines.vh"
`default_nettype none

module status_reporting_registers (
    // clock and power-on reset
    input wire sys_clk_in,
    input wire rst_in,
    // non-volatile settings
    input wire nv_psc_in,
    input wire [7:0] nv_ese_in,
    input wire [7:0] nv_sre_in,
    output wire nv_psc_out,
    output wire [7:0] nv_ese_out,
    output wire [7:0] nv_sre_out,
    // command strobe and answer
    input wire cmd_strobe_in,
    input wire [3:0] cmd_sel_in,
    input wire [15:0] cmd_data_in,
    output wire cmd_ready_out,
    output reg rsp_valid_out,
    output reg [15:0] rsp_data_out,
    // execution progress
    input wire ops_idle_in,
    // questionable conditions
    input wire volt_ovld_in,
    input wire curr_ovld_in,
    input wire ohm_ovld_in,
    input wire limit_lo_in,
    input wire limit_hi_in,
    // standard event conditions
    input wire query_err_in,
    input wire device_err_in,
    input wire exec_err_in,
    input wire cmd_err_in,
    input wire msg_avail_in,
    // error queue producer
    input wire err_push_in,
    input wire [15:0] err_code_in,
    output wire err_full_out,
    // serial poll
    input wire spoll_in,
    output reg spoll_valid_out,
    output reg [7:0] spoll_data_out,
    output wire srq_out,
    // device clear
    input wire dev_clear_in,
    output reg abort_meas_out,
    output reg trig_idle_out,
    output reg flush_buffers_out
);

    // =====================================================
    // state
    reg init_reg;
    reg psc_reg;
    reg [7:0] ese_reg;
    reg [7:0] sre_reg;
    reg [15:0] qen_reg;
    reg opc_pend_reg;
    reg opcq_pend_reg;
    reg rqs_reg;
    reg sum_d_reg;

    wire [7:0] esr_q;
    wire [15:0] ques_q;
    wire [15:0] err_head;
    wire err_empty;

    // the decoder must wait while a *OPC? is outstanding, so the
    // delayed reply never collides with an immediate one
    assign cmd_ready_out = ~init_reg & ~opcq_pend_reg;
    wire cmd_take = cmd_strobe_in & cmd_ready_out;

    // =====================================================
    // select decode
    function hit;
        input take;
        input [3:0] sel;
        input [3:0] code;
        begin
            hit = take & (sel == code);
        end
    endfunction

    wire do_cls = hit(cmd_take, cmd_sel_in, `SEL_CLS);
    wire esr_rd = hit(cmd_take, cmd_sel_in, `SEL_ESR_RD);
    wire qev_rd = hit(cmd_take, cmd_sel_in, `SEL_QEV_RD);
    wire err_rd = hit(cmd_take, cmd_sel_in, `SEL_ERR_RD);
    wire opc_cmd = hit(cmd_take, cmd_sel_in, `SEL_OPC);
    wire opcq_cmd = hit(cmd_take, cmd_sel_in, `SEL_OPC_RD);

    // =====================================================
    // operation complete
    wire opc_fire = (opc_pend_reg | opc_cmd) & ops_idle_in;
    // a *OPC? taken while already idle answers at once, without going pending
    wire opcq_fire = (opcq_pend_reg | opcq_cmd) & ops_idle_in;

    // =====================================================
    // event registers
    wire [7:0] esr_set;
    assign esr_set[`ESR_OPC] = opc_fire;
    assign esr_set[1] = 1'b0;
    assign esr_set[`ESR_QUERY] = query_err_in;
    assign esr_set[`ESR_DEVICE] = device_err_in;
    assign esr_set[`ESR_EXEC] = exec_err_in;
    assign esr_set[`ESR_CMD] = cmd_err_in;
    assign esr_set[6] = 1'b0;
    assign esr_set[`ESR_PON] = init_reg;

    wire [15:0] ques_set;
    assign ques_set[`QUES_VOLT] = volt_ovld_in;
    assign ques_set[`QUES_CURR] = curr_ovld_in;
    assign ques_set[8:2] = 7'h00;
    assign ques_set[`QUES_OHM] = ohm_ovld_in;
    assign ques_set[10] = 1'b0;
    assign ques_set[`QUES_LO] = limit_lo_in;
    assign ques_set[`QUES_HI] = limit_hi_in;
    assign ques_set[15:13] = 3'h0;

    // device clear and *RST do not reach these clears
    event_latch #(
        .W(8),
        .VALID(`ESR_VALID)
    ) u_std_event (
        .clk_in(sys_clk_in),
        .rst_in(rst_in),
        .set_in(esr_set),
        .clr_in(do_cls | esr_rd),
        .q_out(esr_q)
    );

    event_latch #(
        .W(16),
        .VALID(`QUES_VALID)
    ) u_ques_event (
        .clk_in(sys_clk_in),
        .rst_in(rst_in),
        .set_in(ques_set),
        .clr_in(do_cls | qev_rd),
        .q_out(ques_q)
    );

    error_queue u_err_queue (
        .clk_in(sys_clk_in),
        .rst_in(rst_in),
        .push_in(err_push_in),
        .data_in(err_code_in),
        .full_out(err_full_out),
        .pop_in(err_rd),
        .head_out(err_head),
        .empty_out(err_empty)
    );

    // =====================================================
    // status byte
    wire [7:0] stb_low;
    assign stb_low[2:0] = 3'h0;
    assign stb_low[`STB_QUES] = |(ques_q & qen_reg);
    assign stb_low[`STB_MAV] = msg_avail_in;
    assign stb_low[`STB_ESB] = |(esr_q & ese_reg);
    assign stb_low[7:6] = 2'h0;

    wire srq_sum = |(stb_low & sre_reg & `SRE_SUM_MASK);
    wire [7:0] stb = stb_low | ({7'h00, rqs_reg} << `STB_RQS);

    assign srq_out = rqs_reg;
    assign nv_psc_out = psc_reg;
    assign nv_ese_out = ese_reg;
    assign nv_sre_out = sre_reg;

    // =====================================================
    // query answer, values taken before any clear at this edge
    reg [15:0] rd_value;
    reg rd_hit;

    always @*
    begin
        rd_hit = cmd_take;
        rd_value = 16'h0000;
        case (cmd_sel_in)
            `SEL_ESE_RD: rd_value = {8'h00, ese_reg};
            `SEL_ESR_RD: rd_value = {8'h00, esr_q};
            `SEL_PSC_RD: rd_value = {15'h0000, psc_reg};
            `SEL_SRE_RD: rd_value = {8'h00, sre_reg};
            `SEL_STB_RD: rd_value = {8'h00, stb};
            `SEL_QEN_RD: rd_value = qen_reg;
            `SEL_QEV_RD: rd_value = ques_q;
            `SEL_ERR_RD: rd_value = err_head;
            default: rd_hit = 1'b0;
        endcase
    end

    // =====================================================
    // masks, settings and pending flags
    always @(posedge sys_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            init_reg <= 1'b1;
            psc_reg <= 1'b0;
            ese_reg <= `MASK8_RST;
            sre_reg <= `MASK8_RST;
            qen_reg <= `MASK16_RST;
            opc_pend_reg <= 1'b0;
            opcq_pend_reg <= 1'b0;
            rqs_reg <= 1'b0;
            sum_d_reg <= 1'b0;
        end
        else
        begin
            init_reg <= 1'b0;
            sum_d_reg <= srq_sum;
            // rising summary wins over a poll or clear in the same cycle
            rqs_reg <= (rqs_reg & ~(spoll_in | do_cls)) | (srq_sum & ~sum_d_reg);
            if (init_reg)
            begin
                // first edge after power-up restores the stored psc flag, and the stored masks only when that flag is clear
                psc_reg <= nv_psc_in;
                ese_reg <= nv_psc_in ? `MASK8_RST : nv_ese_in;
                sre_reg <= nv_psc_in ? `MASK8_RST : nv_sre_in;
            end
            if (hit(cmd_take, cmd_sel_in, `SEL_ESE_WR))
                ese_reg <= cmd_data_in[7:0];
            if (hit(cmd_take, cmd_sel_in, `SEL_SRE_WR))
                sre_reg <= cmd_data_in[7:0];
            if (hit(cmd_take, cmd_sel_in, `SEL_PSC_WR))
                psc_reg <= (cmd_data_in != 16'h0000);
            if (hit(cmd_take, cmd_sel_in, `SEL_QEN_WR))
                qen_reg <= cmd_data_in & `QUES_VALID;
            else if (hit(cmd_take, cmd_sel_in, `SEL_PRESET))
                qen_reg <= `MASK16_RST;
            // device clear drops waiting completions, nothing else
            if (dev_clear_in)
            begin
                opc_pend_reg <= 1'b0;
                opcq_pend_reg <= 1'b0;
            end
            else
            begin
                opc_pend_reg <= (opc_pend_reg | opc_cmd) & ~ops_idle_in;
                opcq_pend_reg <= (opcq_pend_reg | opcq_cmd) & ~ops_idle_in;
            end
        end
    end

    // =====================================================
    // answers, serial poll and device clear pulses
    always @(posedge sys_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            rsp_valid_out <= 1'b0;
            rsp_data_out <= 16'h0000;
            spoll_valid_out <= 1'b0;
            spoll_data_out <= 8'h00;
            abort_meas_out <= 1'b0;
            trig_idle_out <= 1'b0;
            flush_buffers_out <= 1'b0;
        end
        else
        begin
            rsp_valid_out <= (rd_hit | opcq_fire) & ~dev_clear_in;
            if (opcq_fire)
                rsp_data_out <= `OPC_REPLY;
            else if (rd_hit)
                rsp_data_out <= rd_value;
            spoll_valid_out <= spoll_in;
            if (spoll_in)
                spoll_data_out <= stb;
            abort_meas_out <= dev_clear_in;
            trig_idle_out <= dev_clear_in;
            flush_buffers_out <= dev_clear_in;
        end
    end

endmodule

`default_nettype wire

// [sim/status_checker.sv]
// concurrent checks on the status block ports
// assumes one clock domain and a power-on reset that is active high
`default_nettype none
module status_checker (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // command bus
    input wire logic cmd_strobe_in,
    input wire logic [3:0] cmd_sel_in,
    input wire logic [15:0] cmd_data_in,
    input wire logic cmd_ready_out,
    input wire logic rsp_valid_out,
    input wire logic [15:0] rsp_data_out,
    input wire logic ops_idle_in,
    input wire logic msg_avail_in,
    // poll, clear and stored masks
    input wire logic spoll_in,
    input wire logic spoll_valid_out,
    input wire logic [7:0] spoll_data_out,
    input wire logic srq_out,
    input wire logic dev_clear_in,
    input wire logic abort_meas_out,
    input wire logic trig_idle_out,
    input wire logic flush_buffers_out,
    input wire logic [7:0] nv_ese_out,
    input wire logic [7:0] nv_sre_out,
    input wire logic nv_psc_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========
    // assertions
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (rst_in);
    // a clear in the same cycle may cancel the command, so it is left out
    wire logic take = cmd_strobe_in && cmd_ready_out && !dev_clear_in;
    a_query_answer: assert property (take && (cmd_sel_in inside {2, 3, 7, 9, 10, 12, 13, 15})
        |=> rsp_valid_out) else $error("query gave no answer");
    a_opc_reply: assert property (take && cmd_sel_in == 4'h5 && ops_idle_in
        |=> rsp_valid_out && rsp_data_out == 16'h0001) else $error("bad opc reply");
    a_opc_hold: assert property (take && cmd_sel_in == 4'h5 && !ops_idle_in
        |=> !cmd_ready_out && !rsp_valid_out) else $error("opc reply too early");
    a_ese_load: assert property (take && cmd_sel_in == 4'h1
        |=> {8'h00, nv_ese_out} == ($past(cmd_data_in) & 16'h00FF)) else $error("ese");
    a_sre_load: assert property (take && cmd_sel_in == 4'h8
        |=> {8'h00, nv_sre_out} == ($past(cmd_data_in) & 16'h00FF)) else $error("sre");
    a_psc_load: assert property (take && cmd_sel_in == 4'h6
        |=> nv_psc_out == ($past(cmd_data_in) != 16'h0000)) else $error("psc");
    a_poll_byte: assert property (spoll_in |=> spoll_valid_out
        && spoll_data_out[6] == $past(srq_out) && spoll_data_out[4] == $past(msg_avail_in))
        else $error("poll byte");
    a_stb_unused: assert property (spoll_valid_out |-> (spoll_data_out & 8'h87) == 8'h00)
        else $error("unused status bits set");
    a_clear_pulses: assert property (dev_clear_in
        |=> abort_meas_out && trig_idle_out && flush_buffers_out) else $error("clear");
    a_clear_keeps: assert property (dev_clear_in && !cmd_strobe_in
        |=> $stable(nv_ese_out) && $stable(nv_sre_out) && $stable(nv_psc_out))
        else $error("clear changed masks");
endmodule
`default_nettype wire

// [sim/controller_model.sv]
// remote controller model: command strobes, serial polls, device clears
// assumes each task is entered just after a rising clock edge
`default_nettype none
module controller_model (
    // clock and handshake
    input wire logic clk_in,
    input wire logic ready_in,
    // command bus
    output var logic strobe_out,
    output var logic [3:0] sel_out,
    output var logic [15:0] data_out,
    // bus messages
    output var logic spoll_out,
    output var logic dev_clear_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        strobe_out = 1'b0;
        sel_out = 4'h0;
        data_out = 16'h0000;
        spoll_out = 1'b0;
        dev_clear_out = 1'b0;
    end
    // ==========
    // tasks
    // the strobe stays up through refused cycles, so the caller must release it
    task automatic send(input logic [3:0] sel, input logic [15:0] data);
        strobe_out = 1'b1;
        sel_out = sel;
        data_out = data;
        while (ready_in !== 1'b1)
        begin
            @(posedge clk_in);
            #1;
        end
        @(posedge clk_in);
        #1;
    endtask
    // released lines carry the inverse so stale values cannot look valid
    task automatic rel();
        strobe_out = 1'b0;
        sel_out = ~sel_out;
        data_out = ~data_out;
        @(posedge clk_in);
        #1;
    endtask
    task automatic poll();
        spoll_out = 1'b1;
        @(posedge clk_in);
        #1;
        spoll_out = 1'b0;
    endtask
    task automatic clear();
        dev_clear_out = 1'b1;
        @(posedge clk_in);
        #1;
        dev_clear_out = 1'b0;
    endtask
endmodule
`default_nettype wire

// [sim/testbench.sv]
// self-checking bench for the status block, with the controller model
// assumes the design select codes and a 25 MHz system clock
`include "status_defines.vh"
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst = 1'b1, psc = 1'b0, idle = 1'b1, mav = 1'b0, push = 1'b0;
    logic [7:0] nv_ese = 8'h24, nv_sre = 8'h10;
    logic [4:0] qc = 5'h00;
    logic [3:0] ec = 4'h0;
    logic [15:0] code = 16'h0000;
    wire logic stb, sp, dc, rdy, rv, sv, srq, ab, ti, fl, full, psc_o;
    wire logic [3:0] sel;
    wire logic [15:0] dat, rd;
    wire logic [7:0] sd, ese_o, sre_o;
    int failures = 0, n_compared = 0, cycles = 0;
    controller_model p (.clk_in(clk), .ready_in(rdy), .strobe_out(stb), .sel_out(sel),
        .data_out(dat), .spoll_out(sp), .dev_clear_out(dc));
    status_reporting_registers DUT (.sys_clk_in(clk), .rst_in(rst), .nv_psc_in(psc),
        .nv_ese_in(nv_ese), .nv_sre_in(nv_sre), .nv_psc_out(psc_o), .nv_ese_out(ese_o),
        .nv_sre_out(sre_o), .cmd_strobe_in(stb), .cmd_sel_in(sel), .cmd_data_in(dat),
        .cmd_ready_out(rdy), .rsp_valid_out(rv), .rsp_data_out(rd), .ops_idle_in(idle),
        .volt_ovld_in(qc[0]), .curr_ovld_in(qc[1]), .ohm_ovld_in(qc[2]),
        .limit_lo_in(qc[3]), .limit_hi_in(qc[4]), .query_err_in(ec[0]),
        .device_err_in(ec[1]), .exec_err_in(ec[2]), .cmd_err_in(ec[3]),
        .msg_avail_in(mav), .err_push_in(push), .err_code_in(code), .err_full_out(full),
        .spoll_in(sp), .spoll_valid_out(sv), .spoll_data_out(sd), .srq_out(srq),
        .dev_clear_in(dc), .abort_meas_out(ab), .trig_idle_out(ti), .flush_buffers_out(fl));
    initial
    begin
        forever #20 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            failures++;
            tally_and_finish();
        end
    end
    // ==========
    // shared tasks
    task automatic tally_and_finish();
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic q(input logic [3:0] s, input logic [15:0] exp);
        p.send(s, 16'h0000);
        chk(rv === 1'b1 ? rd : 16'hXXXX, exp);
        p.rel();
    endtask
    task automatic w(input logic [3:0] s, input logic [15:0] d);
        p.send(s, d);
        p.rel();
    endtask
    task automatic reset_dut(input logic set);
        rst = 1'b1;
        psc = set;
        repeat (20) @(posedge clk);
        #1 rst = 1'b0;
        @(posedge clk);
        #1;
    endtask
    task automatic pulse_ev(input logic [4:0] qv, input logic [3:0] ev);
        qc = qv;
        ec = ev;
        @(posedge clk);
        #1;
        qc = 5'h00;
        ec = 4'h0;
    endtask
    // ==========
    // scenarios
    task automatic t_power();
        reset_dut(1'b0);
        chk({ese_o, sre_o}, 16'h2410);
        q(`SEL_ESR_RD, 16'h0080);
        q(`SEL_ESR_RD, 16'h0000);
        q(`SEL_QEN_RD, 16'h0000);
        q(`SEL_PSC_RD, 16'h0000);
        w(`SEL_PSC_WR, 16'h0005);
        q(`SEL_PSC_RD, 16'h0001);
        reset_dut(1'b1);
        chk({ese_o, sre_o}, 16'h0000);
    endtask
    task automatic t_ques();
        w(`SEL_QEN_WR, 16'hFFFF);
        q(`SEL_QEN_RD, 16'h1A03);
        q(`SEL_QEN_RD, 16'h1A03);
        pulse_ev(5'h1F, 4'h0);
        q(`SEL_STB_RD, 16'h0008);
        q(`SEL_QEV_RD, 16'h1A03);
        q(`SEL_QEV_RD, 16'h0000);
        q(`SEL_STB_RD, 16'h0000);
        w(`SEL_PRESET, 16'h0000);
        q(`SEL_QEN_RD, 16'h0000);
    endtask
    task automatic t_esr();
        w(`SEL_ESE_WR, 16'h003C);
        pulse_ev(5'h00, 4'hF);
        q(`SEL_STB_RD, 16'h0020);
        q(`SEL_ESR_RD, 16'h00BC);
        q(`SEL_ESR_RD, 16'h0000);
        w(`SEL_OPC, 16'h0000);
        q(`SEL_ESR_RD, 16'h0001);
        q(`SEL_OPC_RD, 16'h0001);
        w(`SEL_ESE_WR, 16'h0000);
        q(`SEL_ESE_RD, 16'h0000);
    endtask
    task automatic t_opc_wait();
        idle = 1'b0;
        p.send(`SEL_OPC_RD, 16'h0000);
        p.rel();
        repeat (3) @(posedge clk);
        #1;
        chk({14'h0000, rv, rdy}, 16'h0000);
        idle = 1'b1;
        @(posedge clk);
        #1;
        chk(rv === 1'b1 ? rd : 16'hXXXX, 16'h0001);
    endtask
    task automatic t_poll_clear();
        w(`SEL_ESE_WR, 16'h0010);
        w(`SEL_SRE_WR, 16'h0020);
        mav = 1'b1;
        pulse_ev(5'h01, 4'h4);
        // request service rises one cycle after its summary bit
        @(posedge clk);
        #1;
        q(`SEL_STB_RD, 16'h0070);
        q(`SEL_SRE_RD, 16'h0020);
        chk({15'h0000, srq}, 16'h0001);
        p.poll();
        chk({7'h00, sv, sd}, 16'h0170);
        p.clear();
        chk({13'h0000, ab, ti, fl}, 16'h0007);
        q(`SEL_ESE_RD, 16'h0010);
        q(`SEL_QEV_RD, 16'h0001);
        w(`SEL_CLS, 16'h0000);
        q(`SEL_STB_RD, 16'h0010);
        q(`SEL_ESR_RD, 16'h0000);
        mav = 1'b0;
    endtask
    task automatic t_errors();
        for (int i = 0; i < 21; i++)
        begin
            push = 1'b1;
            code = 16'h0100 + 16'(i);
            @(posedge clk);
            #1;
        end
        push = 1'b0;
        chk({15'h0000, full}, 16'h0001);
        for (int i = 0; i < 20; i++)
            q(`SEL_ERR_RD, 16'h0100 + 16'(i));
        q(`SEL_ERR_RD, 16'h0000);
    endtask
    initial
    begin
        t_power();
        t_ques();
        t_esr();
        t_opc_wait();
        t_poll_clear();
        t_errors();
        tally_and_finish();
    end
endmodule
bind status_reporting_registers status_checker chk_i (.*);
`default_nettype wire
